// >>> hw/taf_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module taf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    taf_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    logic do_wr;
    logic do_rd;

    // full and empty come straight from the fill count
    // compare at the fill count's own width; a depth that is a power of two does not fit AW bits
    assign port.in_ready = (fill != (AW+1)'(DEPTH));
    assign port.out_valid = (fill != '0);
    assign port.out_data = mem[rd_ptr];
    assign do_wr = port.in_valid && port.in_ready;
    assign do_rd = port.out_valid && port.out_ready;

    // storage, no reset needed on data
    always_ff @(posedge sys_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= port.in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            fill <= fill + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : taf_fifo

// >>> hw/taf_framer.sv
// sweep trace attribute framer: prefix, extra header and grouped trace payload
//
// Contract
// - payload starts count, channel, header length, flags
// - channel field is zero for the receiver
// - measurement selector bits as listed
// - channel, frequency low and high selector bits
// - swap flag sends trace data little-endian
// - flag extra header present and above threshold
// - data sets in ascending flag order
// - item only when configuration and sensors permit
// - all flags apply, sweep header describes packet
// - sweep count and dwell, minus one infinite
// - hold time, direction and signal stop fields
// - start, step, stop frequencies low and high
// - header ends with 64-bit emit time
// - header length is zero or forty
// - values signed tenths, one per item
// - each type one contiguous block of items
// - frequency low block precedes high block
// - new header fields only appended at end
// - protocol fields big-endian unless swapped; prefix and header here stay big-endian with swap set
// - attribute tag and length precede payload
`timescale 1ns/1ps
module taf_framer
    import taf_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [15:0] per_type_item_count_in,
    input wire logic [31:0] config_flags_in,
    input wire logic [31:0] sensor_flags_in,
    input wire logic swap_enable_in,
    input wire logic above_threshold_flag_in,
    input wire logic hdr_enable_in,
    input wire logic [15:0] sweep_total_in,
    input wire logic sweep_infinite_in,
    input wire logic [15:0] signal_hold_ms_in,
    input wire logic [15:0] per_step_linger_ms_in,
    input wire logic linger_infinite_in,
    input wire logic sweep_direction_in,
    input wire logic signal_stop_enable_in,
    input wire logic [31:0] sweep_begin_lower_in,
    input wire logic [31:0] sweep_end_lower_in,
    input wire logic [31:0] sweep_increment_hz_in,
    input wire logic [31:0] sweep_begin_upper_in,
    input wire logic [31:0] sweep_end_upper_in,
    input wire logic [63:0] emit_time_ns_in,
    input wire logic item_valid_in,
    input wire logic [31:0] item_data_in,
    input wire logic byte_ready_in,
    output logic busy_out,
    output logic item_req_out,
    output logic [4:0] item_flag_out,
    output logic [15:0] item_index_out,
    output logic [7:0] byte_data_out,
    output logic byte_valid_out,
    output logic byte_last_out
);
    // bytes per item over all selected types
    function automatic logic [15:0] item_bytes(input logic [31:0] sel);
        logic [15:0] sum;
        sum = '0;
        for (int b = 0; b < 32; b++) begin
            if (sel[b]) begin
                sum = sum + (TAF_LONG_MASK[b] ? 16'h0004 : 16'h0002);
            end
        end
        return sum;
    endfunction : item_bytes

    // flags strictly above a bit position
    function automatic logic [31:0] above_mask(input logic [4:0] b);
        return ~((32'h00000002 << b) - 32'h00000001);
    endfunction : above_mask

    // byte k of an item word, most significant first unless swapped
    function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] k,
            input logic swap, input logic long_w);
        logic [1:0] pos;
        pos = swap ? k : ((long_w ? 2'h3 : 2'h1) - k);
        return w[{pos, 3'b000} +: 8];
    endfunction : pick_byte

    taf_fifo_if #(.WIDTH(9)) fq ();

    taf_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .port(fq.fifo)
    );

    taf_state_t state;
    logic [415:0] head;
    logic [5:0] head_left;
    logic [31:0] sel;
    logic [31:0] flags_sent;
    logic [15:0] item_count;
    logic swap;
    logic [4:0] cur_bit;
    logic [15:0] idx;
    logic [1:0] k;
    logic [31:0] word;
    logic [31:0] next_sel;
    logic [31:0] next_flags;
    logic [7:0] next_hdr_len;
    logic [15:0] next_len;
    logic [415:0] next_head;
    logic no_data;
    logic cur_long;
    logic item_end;
    logic block_end;
    logic frame_end;
    logic wr_ok;
    logic start_ok;

    // selection: configuration, sensors and trace type must all permit
    assign next_sel = config_flags_in & sensor_flags_in & TAF_DATA_MASK;
    assign next_hdr_len = hdr_enable_in ? TAF_HDR_BYTES_FULL : TAF_HDR_BYTES_NONE;
    assign next_flags = next_sel
        | (swap_enable_in ? TAF_FLG_SWAP : '0)
        | (above_threshold_flag_in ? TAF_FLG_SQUELCH : '0)
        | (hdr_enable_in ? TAF_FLG_OPT_HDR : '0);
    // attribute length excludes tag and length; products wrap at 16 bits
    assign next_len = TAF_FIXED_BYTES + {8'h00, next_hdr_len}
        + 16'(per_type_item_count_in * item_bytes(next_sel));

    // prefix then sweep header, fields in their fixed order
    assign next_head = {
        TAF_TAG_SWEEP, next_len,
        per_type_item_count_in, TAF_CHAN_RX, next_hdr_len, next_flags,
        sweep_infinite_in ? TAF_INFINITE : sweep_total_in,
        signal_hold_ms_in,
        linger_infinite_in ? TAF_INFINITE : per_step_linger_ms_in,
        15'h0000, sweep_direction_in, 15'h0000, signal_stop_enable_in,
        sweep_begin_lower_in, sweep_end_lower_in, sweep_increment_hz_in,
        sweep_begin_upper_in, sweep_end_upper_in,
        TAF_ALIGN_PAD,
        emit_time_ns_in
    };

    assign no_data = (item_count == 16'h0000) || (sel == 32'h00000000);
    assign cur_long = TAF_LONG_MASK[cur_bit];
    assign item_end = (k == (cur_long ? 2'h3 : 2'h1));
    assign block_end = item_end && (idx == item_count - 16'h0001);
    assign frame_end = block_end && ((sel & above_mask(cur_bit)) == '0);
    assign wr_ok = fq.in_ready;
    assign start_ok = (state == TAF_IDLE) && start_in;

    // bytes into the fifo; a stalled fifo holds the sequencer
    always_comb begin
        fq.in_valid = 1'b0;
        fq.in_data = '0;
        if (state == TAF_HEAD) begin
            fq.in_valid = 1'b1;
            fq.in_data = {(head_left == 6'h01) && no_data, head[415:408]};
        end else if (state == TAF_EMIT) begin
            fq.in_valid = 1'b1;
            fq.in_data = {frame_end, pick_byte(word, k, swap, cur_long)};
        end
    end

    // header shift register, loaded at start and shifted a byte per write
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            head <= '0;
            head_left <= '0;
        end else if (start_ok) begin
            head <= next_head;
            // without the extra header only the fixed prefix goes out
            head_left <= hdr_enable_in ? TAF_HEAD_BYTES : TAF_PREFIX_BYTES;
        end else if ((state == TAF_HEAD) && wr_ok) begin
            head <= {head[407:0], 8'h00};
            head_left <= head_left - 6'h01;
        end
    end

    // frame parameters held for the whole frame
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            sel <= '0;
            flags_sent <= '0;
            item_count <= '0;
            swap <= 1'b0;
        end else if (start_ok) begin
            sel <= next_sel;
            flags_sent <= next_flags;
            item_count <= per_type_item_count_in;
            swap <= swap_enable_in;
        end
    end

    // sequencer: header, then one block per selected type, lowest flag first
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state <= TAF_IDLE;
            cur_bit <= '0;
            idx <= '0;
            k <= '0;
            word <= '0;
            item_req_out <= 1'b0;
        end else begin
            unique case (state)
                TAF_IDLE: begin
                    if (start_in) begin
                        state <= TAF_HEAD;
                        cur_bit <= '0;
                    end
                end
                TAF_HEAD: begin
                    if (wr_ok && (head_left == 6'h01)) begin
                        state <= no_data ? TAF_IDLE : TAF_SEL;
                    end
                end
                TAF_SEL: begin
                    if (sel[cur_bit]) begin
                        state <= TAF_FETCH;
                        idx <= '0;
                        item_req_out <= 1'b1;
                    end else begin
                        cur_bit <= cur_bit + 5'h01;
                    end
                end
                TAF_FETCH: begin
                    if (item_valid_in) begin
                        word <= item_data_in;
                        k <= '0;
                        item_req_out <= 1'b0;
                        state <= TAF_EMIT;
                    end
                end
                TAF_EMIT: begin
                    if (wr_ok) begin
                        if (frame_end) begin
                            state <= TAF_IDLE;
                        end else if (block_end) begin
                            // next type; frequency low bit sits below high bit
                            cur_bit <= cur_bit + 5'h01;
                            state <= TAF_SEL;
                        end else if (item_end) begin
                            idx <= idx + 16'h0001;
                            item_req_out <= 1'b1;
                            state <= TAF_FETCH;
                        end else begin
                            k <= k + 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // busy and the item address follow the sequencer
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            busy_out <= 1'b0;
        end else if (start_ok) begin
            busy_out <= 1'b1;
        end else if (((state == TAF_HEAD) && wr_ok && (head_left == 6'h01) && no_data)
                || ((state == TAF_EMIT) && wr_ok && frame_end)) begin
            busy_out <= 1'b0;
        end
    end

    assign item_flag_out = cur_bit;
    assign item_index_out = idx;

    // output register so every stream pin comes from a flop
    assign fq.out_ready = !byte_valid_out || byte_ready_in;
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            byte_valid_out <= 1'b0;
            byte_data_out <= '0;
            byte_last_out <= 1'b0;
        end else if (fq.out_ready) begin
            byte_valid_out <= fq.out_valid;
            byte_data_out <= fq.out_data[7:0];
            byte_last_out <= fq.out_data[8] && fq.out_valid;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_idle_no_write: assert property ((state == TAF_IDLE) |-> !fq.in_valid)
        else $error("byte written while idle");
    a_tag_first: assert property (start_ok |=> (head[415:400] == TAF_TAG_SWEEP)
        && (head_left == ($past(hdr_enable_in) ? TAF_HEAD_BYTES : TAF_PREFIX_BYTES)))
        else $error("frame does not open with the sweep tag");
    a_chan_zero: assert property (start_ok |=> head[367:360] == TAF_CHAN_RX)
        else $error("channel field not zero");
    a_hdr_len: assert property (start_ok |=> (head[359:352] ==
        (head[351] ? TAF_HDR_BYTES_FULL : TAF_HDR_BYTES_NONE)))
        else $error("header length disagrees with header flag");
    a_flag_subset: assert property (start_ok |=> ((flags_sent & TAF_DATA_MASK)
        & ~($past(config_flags_in) & $past(sensor_flags_in))) == '0)
        else $error("data flag set without permission");
    a_swap_flag: assert property ($rose(busy_out)
        |-> ((flags_sent & TAF_FLG_SWAP) != '0) == swap)
        else $error("swap flag and byte order disagree");
    a_sel_order: assert property ((state == TAF_FETCH) |-> sel[cur_bit]
        && ((sel & ~above_mask(cur_bit) & ~(32'h00000001 << cur_bit)
        & ~$past(sel)) == '0))
        else $error("fetching an unselected type");
    a_bit_rise: assert property ((state == TAF_SEL) && !sel[cur_bit] |=> $past(cur_bit)
        + 5'h01 == cur_bit)
        else $error("selector scan skipped a flag");
    a_req_drop: assert property (item_req_out && item_valid_in |=> !item_req_out
        ##1 (state == TAF_EMIT) || !item_req_out)
        else $error("item request held after accept");
    a_infinite: assert property (start_ok && sweep_infinite_in |=>
        head[319:304] == TAF_INFINITE)
        else $error("infinite sweep count not minus one");

    c_swap_frame: cover property ((state == TAF_EMIT) && swap && frame_end && wr_ok);
    c_no_header: cover property (start_ok && !hdr_enable_in);
    c_full_fifo: cover property (busy_out && !fq.in_ready);
    c_long_item: cover property ((state == TAF_EMIT) && cur_long && item_end && wr_ok);
endmodule : taf_framer

// >>> include/taf_fifo_if.sv
// valid/ready carrier between the framer core and its byte fifo
`timescale 1ns/1ps
interface taf_fifo_if #(parameter int WIDTH = 9);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, input in_data, input out_ready,
        output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
        input in_ready, input out_valid, input out_data);
endinterface : taf_fifo_if

// >>> include/taf_pkg.sv
// constants, flag layout and states for the trace attribute framer
package taf_pkg;
    localparam logic [15:0] TAF_TAG_SWEEP = 16'h0065;
    localparam logic [7:0] TAF_CHAN_RX = 8'h00;
    // value older sub-revisions used for the same receiver, never sent here
    localparam logic [7:0] TAF_CHAN_RX_LEGACY = 8'h77;
    localparam logic [7:0] TAF_LEGACY_SUBREV_MAX = 8'h31;
    localparam logic [7:0] TAF_HDR_BYTES_FULL = 8'h28;
    localparam logic [7:0] TAF_HDR_BYTES_NONE = 8'h00;
    localparam logic [15:0] TAF_FIXED_BYTES = 16'h0008;
    localparam logic [5:0] TAF_PREFIX_BYTES = 6'h0C;
    localparam logic [5:0] TAF_HEAD_BYTES = 6'h34;
    localparam logic [15:0] TAF_INFINITE = 16'hFFFF;
    localparam logic [15:0] TAF_ALIGN_PAD = 16'h0000;
    localparam logic [31:0] TAF_FLG_LEVEL = 32'h00000001;
    localparam logic [31:0] TAF_FLG_OFFSET = 32'h00000002;
    localparam logic [31:0] TAF_FLG_FSTRENGTH = 32'h00000004;
    localparam logic [31:0] TAF_FLG_AM = 32'h00000008;
    localparam logic [31:0] TAF_FLG_AM_POS = 32'h00000010;
    localparam logic [31:0] TAF_FLG_AM_NEG = 32'h00000020;
    localparam logic [31:0] TAF_FLG_FM = 32'h00000040;
    localparam logic [31:0] TAF_FLG_FM_POS = 32'h00000080;
    localparam logic [31:0] TAF_FLG_FM_NEG = 32'h00000100;
    localparam logic [31:0] TAF_FLG_PM = 32'h00000200;
    localparam logic [31:0] TAF_FLG_BANDWIDTH = 32'h00000400;
    localparam logic [31:0] TAF_FLG_DF_LEVEL = 32'h00000800;
    localparam logic [31:0] TAF_FLG_AZIMUTH = 32'h00001000;
    localparam logic [31:0] TAF_FLG_DF_QUALITY = 32'h00002000;
    localparam logic [31:0] TAF_FLG_DF_FSTRENGTH = 32'h00004000;
    localparam logic [31:0] TAF_FLG_CHANNEL = 32'h00010000;
    localparam logic [31:0] TAF_FLG_FREQ_LOW = 32'h00020000;
    localparam logic [31:0] TAF_FLG_FREQ_HIGH = 32'h00200000;
    localparam logic [31:0] TAF_FLG_SWAP = 32'h20000000;
    localparam logic [31:0] TAF_FLG_SQUELCH = 32'h04000000;
    localparam logic [31:0] TAF_FLG_OPT_HDR = 32'h80000000;
    // every data flag; all apply to a sweep trace
    localparam logic [31:0] TAF_DATA_MASK = TAF_FLG_LEVEL | TAF_FLG_OFFSET | TAF_FLG_FSTRENGTH
        | TAF_FLG_AM | TAF_FLG_AM_POS | TAF_FLG_AM_NEG | TAF_FLG_FM | TAF_FLG_FM_POS
        | TAF_FLG_FM_NEG | TAF_FLG_PM | TAF_FLG_BANDWIDTH | TAF_FLG_DF_LEVEL
        | TAF_FLG_AZIMUTH | TAF_FLG_DF_QUALITY | TAF_FLG_DF_FSTRENGTH | TAF_FLG_CHANNEL
        | TAF_FLG_FREQ_LOW | TAF_FLG_FREQ_HIGH;
    // data types carried as 32-bit words, the rest are 16-bit
    localparam logic [31:0] TAF_LONG_MASK = TAF_FLG_OFFSET | TAF_FLG_FM | TAF_FLG_FM_POS
        | TAF_FLG_FM_NEG | TAF_FLG_BANDWIDTH | TAF_FLG_FREQ_LOW | TAF_FLG_FREQ_HIGH;
    typedef enum logic [4:0] {
        TAF_IDLE = 5'b00001,
        TAF_HEAD = 5'b00010,
        TAF_SEL = 5'b00100,
        TAF_FETCH = 5'b01000,
        TAF_EMIT = 5'b10000
    } taf_state_t;
endpackage : taf_pkg

// >>> verification/taf_host_model.sv
// host-side sink model: takes stream bytes, stalls on request, finds the trace data
`timescale 1ns/1ps
module taf_host_model (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic slow_in,
    input wire logic [7:0] byte_data_in,
    input wire logic byte_valid_in,
    input wire logic byte_last_in,
    output logic byte_ready_out
);
    logic [7:0] rx_q[$];
    int frame_cnt = 0;
    int last_idx = -1;
    int data_start = 0;
    logic [1:0] pace = 2'h0;
    initial byte_ready_out = 1'b0;
    // a slow host takes one byte in four, so the fifo backs up and stalls the sequencer
    always @(negedge sys_clk_in) begin
        pace <= pace + 2'h1;
        byte_ready_out <= !sys_rst_in && (!slow_in || pace == 2'h3);
    end
    // collect accepted bytes; the marked byte closes a frame
    always @(posedge sys_clk_in) begin
        if (!sys_rst_in && byte_valid_in && byte_ready_out) begin
            rx_q.push_back(byte_data_in);
            if (byte_last_in) begin
                last_idx = rx_q.size() - 1;
                // trace data found by skipping the advertised header length, never a fixed size
                data_start = 12 + int'(rx_q[7]);
                frame_cnt++;
            end
        end
    end
endmodule : taf_host_model

// >>> verification/testbench.sv
// self-checking bench for the sweep trace attribute framer
`timescale 1ns/1ps
module testbench;
    import taf_pkg::*;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic start = 1'b0;
    logic [15:0] count = 16'h0000;
    logic [31:0] cfg = 32'h00000000;
    logic [31:0] sens = 32'h00000000;
    logic swap = 1'b0, thr = 1'b0, hdr = 1'b0, inf = 1'b0, slow = 1'b0;
    logic [15:0] total = 16'h0005, hold = 16'h0064, linger = 16'h0032;
    logic [31:0] blo = 32'h05F5E100, elo = 32'h0BEBC200, stp = 32'h00002710;
    logic [31:0] bhi = 32'h00000001, ehi = 32'h00000002;
    logic [63:0] tstamp = 64'h0123456789ABCDEF;
    logic item_valid = 1'b0;
    logic [31:0] item_data = 32'h00000000;
    logic busy, req, bvalid, blast, bready;
    logic [4:0] iflag;
    logic [15:0] iidx;
    logic [7:0] bdata;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int check_count = 0;

    always #20 sys_clk_in = ~sys_clk_in;

    taf_framer taf_framer_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .start_in(start), .per_type_item_count_in(count), .config_flags_in(cfg),
        .sensor_flags_in(sens), .swap_enable_in(swap), .above_threshold_flag_in(thr),
        .hdr_enable_in(hdr), .sweep_total_in(total), .sweep_infinite_in(inf),
        .signal_hold_ms_in(hold), .per_step_linger_ms_in(linger), .linger_infinite_in(inf),
        .sweep_direction_in(inf), .signal_stop_enable_in(inf), .sweep_begin_lower_in(blo),
        .sweep_end_lower_in(elo), .sweep_increment_hz_in(stp), .sweep_begin_upper_in(bhi),
        .sweep_end_upper_in(ehi), .emit_time_ns_in(tstamp), .item_valid_in(item_valid),
        .item_data_in(item_data), .byte_ready_in(bready), .busy_out(busy),
        .item_req_out(req), .item_flag_out(iflag), .item_index_out(iidx),
        .byte_data_out(bdata), .byte_valid_out(bvalid), .byte_last_out(blast));

    taf_host_model taf_host_model_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .slow_in(slow), .byte_data_in(bdata), .byte_valid_in(bvalid),
        .byte_last_in(blast), .byte_ready_out(bready));

    // item value names its flag and index; a 16-bit type sends only the index bytes, so only 32-bit items show the flag in the stream
    function automatic logic [31:0] item_val(input logic [4:0] f, input logic [15:0] i);
        return {8'hC3, 3'h0, f, i};
    endfunction : item_val

    // item source answers each request; when slow it answers only every other cycle
    always @(negedge sys_clk_in) begin
        item_valid <= req && (!slow || !item_valid);
        item_data <= item_val(iflag, iidx);
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic push(input logic [63:0] v, input int n, input bit le);
        for (int k = 0; k < n; k++) exp_q.push_back(le ? v[8*k+:8] : v[8*(n-1-k)+:8]);
    endtask : push

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // expected frame: prefix and header big-endian, data grouped by ascending flag
    task automatic build();
        int bpi;
        logic [31:0] sel;
        logic [31:0] flags;
        sel = cfg & sens & TAF_DATA_MASK;
        bpi = 0;
        for (int b = 0; b < 32; b++) if (sel[b]) bpi += TAF_LONG_MASK[b] ? 4 : 2;
        flags = sel | (swap ? 32'h20000000 : 32'h0) | (thr ? 32'h04000000 : 32'h0)
            | (hdr ? 32'h80000000 : 32'h0);
        exp_q.delete();
        push(64'h0065, 2, 0);
        push(8 + (hdr ? 40 : 0) + int'(count) * bpi, 2, 0);
        push(count, 2, 0);
        push(64'h00, 1, 0);
        push(hdr ? 64'h28 : 64'h00, 1, 0);
        push(flags, 4, 0);
        if (hdr) begin
            push(inf ? 64'hFFFF : total, 2, 0);
            push(hold, 2, 0);
            push(inf ? 64'hFFFF : linger, 2, 0);
            push(inf, 2, 0);
            push(inf, 2, 0);
            push(blo, 4, 0);
            push(elo, 4, 0);
            push(stp, 4, 0);
            push(bhi, 4, 0);
            push(ehi, 4, 0);
            push(64'h0000, 2, 0);
            push(tstamp, 8, 0);
        end
        for (int b = 0; b < 32; b++)
            if (sel[b])
                for (int i = 0; i < int'(count); i++)
                    push(item_val(5'(b), 16'(i)), TAF_LONG_MASK[b] ? 4 : 2, swap);
    endtask : build

    // one frame, with a second start while busy that must be ignored
    task automatic run(input string name, input logic [15:0] c, input logic [31:0] cf,
            input logic [31:0] sn, input logic [4:0] m);
        int frames;
        @(negedge sys_clk_in);
        {count, cfg, sens} = {c, cf, sn};
        {swap, thr, hdr, inf, slow} = m;
        build();
        taf_host_model_inst.rx_q.delete();
        frames = taf_host_model_inst.frame_cnt;
        start = 1'b1;
        @(negedge sys_clk_in);
        start = 1'b0;
        repeat (5) @(negedge sys_clk_in);
        start = 1'b1;
        @(negedge sys_clk_in);
        start = 1'b0;
        for (int w = 0; taf_host_model_inst.frame_cnt == frames; w++) begin
            if (w > 5000) begin
                check({name, " timeout"}, 1, 0);
                end_sim();
            end
            @(negedge sys_clk_in);
        end
        repeat (30) @(negedge sys_clk_in);
        check({name, " busy"}, busy, 1'b0);
        check({name, " size"}, taf_host_model_inst.rx_q.size(), exp_q.size());
        check({name, " last"}, taf_host_model_inst.last_idx, exp_q.size() - 1);
        check({name, " skip"}, taf_host_model_inst.data_start, hdr ? 52 : 12);
        for (int k = 0; k < exp_q.size() && k < taf_host_model_inst.rx_q.size(); k++)
            check({name, " byte"}, taf_host_model_inst.rx_q[k], exp_q[k]);
        $display("test %s done", name);
    endtask : run

    initial begin
        repeat (5) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        check("reset", {busy, req, bvalid, blast}, 4'h0);
        // mode bits: swap, threshold, header, infinite, slow host
        run("header_be", 16'h0003, 32'hFFFFFFFF, 32'h00230003, 5'b01100);
        run("all_swap", 16'h0001, 32'hFFFFFFFF, 32'hFFFFFFFF, 5'b10111);
        run("cfg_sens", 16'h0002, 32'h08000049, 32'h00000248, 5'b00000);
        run("empty", 16'h0000, 32'hFFFFFFFF, 32'hFFFFFFFF, 5'b01101);
        run("long_slow", 16'h0006, 32'h00220442, 32'hFFFFFFFF, 5'b11001);
        end_sim();
    end
endmodule : testbench
